// >>> design/rft_pkg.sv
// constants, field layout and types of the timer1/timer2 control block
// assumes an 8-bit register port and one 40 MHz clock
package rft_pkg;

    // ************************************************
    // register offsets
    // ************************************************
    localparam logic [7:0] ADDR_T0_CNT_LO  = 8'h13; // timer0_count_low
    localparam logic [7:0] ADDR_T1_CTRL    = 8'h14; // timer1_control
    localparam logic [7:0] ADDR_T1_RLD_HI  = 8'h15; // timer1_reload_high
    localparam logic [7:0] ADDR_T1_RLD_LO  = 8'h16; // timer1_reload_low
    localparam logic [7:0] ADDR_T1_CNT_HI  = 8'h17; // timer1_count_high
    localparam logic [7:0] ADDR_T1_CNT_LO  = 8'h18; // timer1_count_low
    localparam logic [7:0] ADDR_T2_CTRL    = 8'h19; // timer2_control
    localparam logic [7:0] ADDR_IRQ_STAT   = 8'h20; // sticky underflow flags
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h21; // interrupt mask

    // ************************************************
    // field positions and reset values
    // ************************************************
    localparam int unsigned STOP_RX_BIT = 7;       // stop on receive
    localparam int unsigned START_LSB   = 4;       // start mode, two bits
    localparam int unsigned AUTO_BIT    = 3;       // auto reload
    localparam int unsigned CLK_LSB     = 0;       // clock select, two bits
    localparam logic [7:0]  CTRL_WMASK  = 8'hbb;   // reserved bits 6 and 2 read zero
    localparam logic [7:0]  CTRL_RST    = 8'h00;   // control reset value
    localparam logic [7:0]  RELOAD_RST  = 8'h00;   // reload byte reset value
    localparam int unsigned IRQ_T1_BIT  = 0;       // timer1_underflow_flag
    localparam int unsigned IRQ_T2_BIT  = 1;       // timer2_underflow_flag
    localparam logic [1:0]  IRQ_RST     = 2'h0;    // flags and mask reset

    // ************************************************
    // types
    // ************************************************
    typedef enum logic [1:0] {
        START_NONE     = 2'b00, // no automatic start
        START_TX_END   = 2'b01, // start at end of transmission
        START_LFO_NOUF = 2'b10, // oscillator trimming, no underflow
        START_LFO_UF   = 2'b11  // oscillator trimming with underflow
    } rft_start_t;

    typedef enum logic [1:0] {
        CLK_RF    = 2'b00, // 13.56 MHz carrier
        CLK_DIV   = 2'b01, // divided carrier
        CLK_T0    = 2'b10, // timer0 underflow
        CLK_OTHER = 2'b11  // the other timer's underflow
    } rft_clksel_t;

    typedef enum logic {
        ST_IDLE = 1'b0, // stopped
        ST_RUN  = 1'b1  // counting
    } rft_state_t;

endpackage

// >>> design/rft_sync2.sv
// two-flop synchroniser with rising-edge detect
// assumes an asynchronous level input and the block clock
`timescale 1ns/1ps
`default_nettype none
module rft_sync2 (
    input  wire logic mclk_i,  // block clock
    input  wire logic rst_n_i, // synchronous reset, active low
    input  wire logic async_i, // level from outside the clock domain
    output logic      rise_o   // one-cycle pulse on a rising edge
);
    logic meta_q; // first stage, read only by the second
    logic sync_q; // second stage
    logic prev_q; // delayed copy for edge detect

    // ************************************************
    // synchroniser chain
    // ************************************************
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign rise_o = sync_q & ~prev_q;
endmodule
`default_nettype wire

// >>> design/rft_timer_ctrl.sv
// What this block does
// (R1) timer1 count readable as two bytes
// (R2) host avoids counter reads during reception
// (R3) timer1 stops after first 4 received bits
// (R4) timer1 receive stop ignored while trimming
// (R5) start mode 01 starts at tx end
// (R6) modes 10/11 trim oscillator on edges
// (R7) timer1 auto reload restarts, else stops
// (R8) timer1 underflow sets its flag
// (R9) timer1 clock: carrier, divided, timer0, timer2
// (R10) start event loads 16-bit reload value; timer2 loads zero here
// (R11) reload writes wait for next start or auto reload
// (R12) timer2 stops after first 4 bits
// (R13) timer2 receive stop ignored while trimming
// (R14) timer2 start modes match timer1
// (R15) timer2 auto reload restarts, else stops
// (R16) timer2 underflow sets its flag
// (R17) timer2 clock: carrier, divided, timer0, timer1
// (R18) running bit changes only with enable; here also on tx end, oscillator edges, receive stop and one-shot underflow
// (R19) each tick decrements; past zero underflows
//
// registers, tick selection and interrupt for timer1 and timer2
// assumes the register port master of the same clock, carrier,
// divided carrier and oscillator arriving as asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module rft_timer_ctrl (
    input  wire logic       mclk_i,                   // 40 MHz block clock
    input  wire logic       rst_n_i,                  // synchronous reset, active low
    input  wire logic [7:0] addr_i,                   // register address
    input  wire logic [7:0] wdata_i,                  // write data
    input  wire logic       wr_i,                     // write strobe
    input  wire logic       rd_i,                     // read strobe
    output logic      [7:0] rdata_o,                  // read data, cycle after rd_i
    input  wire logic       rf_clk_i,                 // 13.56 MHz carrier level
    input  wire logic       div_clk_i,                // divided carrier level
    input  wire logic       low_freq_oscillator_i,    // oscillator level
    input  wire logic       tx_end_i,                 // end of transmission pulse
    input  wire logic       rx_first4_i,              // first 4 bits received pulse
    input  wire logic       timer0_underflow_i,       // timer0 underflow pulse
    input  wire logic [7:0] timer0_count_low_i,       // timer0 count low byte
    input  wire logic       timer1_run_write_enable_i, // enable for timer1 running
    input  wire logic       timer1_running_i,         // new timer1 running bit
    input  wire logic       timer2_run_write_enable_i, // enable for timer2 running
    input  wire logic       timer2_running_i,         // new timer2 running bit
    output logic            timer1_running_o,         // timer1 counting
    output logic            timer2_running_o,         // timer2 counting
    output logic            timer1_underflow_o,       // timer1 underflow pulse
    output logic            timer2_underflow_o,       // timer2 underflow pulse
    output logic            irq_o                     // level interrupt
);
    import rft_pkg::*;

    // ************************************************
    // declarations
    // ************************************************
    logic [7:0]  t1_ctrl_q;   // timer1_control
    logic [7:0]  t1_rld_hi_q; // timer1_reload_high
    logic [7:0]  t1_rld_lo_q; // timer1_reload_low
    logic [7:0]  t2_ctrl_q;   // timer2_control
    logic [1:0]  stat_q;      // sticky underflow flags
    logic [1:0]  mask_q;      // interrupt mask
    logic [15:0] t1_count;    // timer1 count
    logic [15:0] t2_count;    // timer2 count
    logic [15:0] t2_reload;   // timer2_reload_value, tied to zero here
    logic        t1_run;      // timer1 running
    logic        t2_run;      // timer2 running
    logic        t1_uf;       // timer1 underflow pulse
    logic        t2_uf;       // timer2 underflow pulse
    logic        rf_tick;     // carrier edge
    logic        div_tick;    // divided carrier edge
    logic        lfo_rise;    // oscillator edge
    logic        t1_tick;     // timer1 count clock
    logic        t2_tick;     // timer2 count clock
    logic        wr_ctrl1;    // write to timer1_control
    logic        wr_ctrl2;    // write to timer2_control
    logic        wr_stat;     // write to flag register
    logic [7:0]  rdata_d;     // read mux
    logic [1:0]  uf_set;      // flag set terms

    // ************************************************
    // tick selection shared by both timers
    // ************************************************
    // picks one of the four count sources
    function automatic logic sel_tick(input logic [1:0] sel,
                                      input logic       rf,
                                      input logic       dv,
                                      input logic       t0,
                                      input logic       other);
        logic r;
        r = 1'b0;
        case (sel)
            CLK_RF:    r = rf;
            CLK_DIV:   r = dv;
            CLK_T0:    r = t0;
            CLK_OTHER: r = other;
            default:   r = 1'b0;
        endcase
        return r;
    endfunction

    // ************************************************
    // synchronisers for outside levels
    // ************************************************
    // carrier edge
    rft_sync2 u_sync_rf (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .async_i (rf_clk_i),
        .rise_o  (rf_tick)
    );

    // divided carrier edge
    rft_sync2 u_sync_div (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .async_i (div_clk_i),
        .rise_o  (div_tick)
    );

    // oscillator edge for trimming
    rft_sync2 u_sync_lfo (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .async_i (low_freq_oscillator_i),
        .rise_o  (lfo_rise)
    );

    // timer1: 10 timer0, 11 timer2
    assign t1_tick = sel_tick(t1_ctrl_q[CLK_LSB+:2], rf_tick, div_tick,
                              timer0_underflow_i, t2_uf); // R9
    // timer2: 10 timer0, 11 timer1
    assign t2_tick = sel_tick(t2_ctrl_q[CLK_LSB+:2], rf_tick, div_tick,
                              timer0_underflow_i, t1_uf); // R17

    // timer2 reload bytes live outside this block; zero here
    assign t2_reload = 16'h0000;

    // ************************************************
    // timer cores
    // ************************************************
    // timer1
    rft_tmr_core u_t1 (
        .mclk_i        (mclk_i),
        .rst_n_i       (rst_n_i),
        .stop_rx_i     (t1_ctrl_q[STOP_RX_BIT]),
        .start_mode_i  (rft_start_t'(t1_ctrl_q[START_LSB+:2])),
        .auto_reload_i (t1_ctrl_q[AUTO_BIT]),
        .reload_i      ({t1_rld_hi_q, t1_rld_lo_q}),
        .tick_i        (t1_tick),
        .tx_end_i      (tx_end_i),
        .rx_first4_i   (rx_first4_i),
        .lfo_rise_i    (lfo_rise),
        .run_we_i      (timer1_run_write_enable_i),
        .run_val_i     (timer1_running_i),
        .count_o       (t1_count),
        .running_o     (t1_run),
        .uflow_o       (t1_uf)
    );

    // timer2, same start modes as timer1
    rft_tmr_core u_t2 (
        .mclk_i        (mclk_i),
        .rst_n_i       (rst_n_i),
        .stop_rx_i     (t2_ctrl_q[STOP_RX_BIT]),
        .start_mode_i  (rft_start_t'(t2_ctrl_q[START_LSB+:2])), // R14
        .auto_reload_i (t2_ctrl_q[AUTO_BIT]),
        .reload_i      (t2_reload),
        .tick_i        (t2_tick),
        .tx_end_i      (tx_end_i),
        .rx_first4_i   (rx_first4_i),
        .lfo_rise_i    (lfo_rise),
        .run_we_i      (timer2_run_write_enable_i),
        .run_val_i     (timer2_running_i),
        .count_o       (t2_count),
        .running_o     (t2_run),
        .uflow_o       (t2_uf)
    );

    // ************************************************
    // write decode
    // ************************************************
    assign wr_ctrl1 = wr_i && (addr_i == ADDR_T1_CTRL);
    assign wr_ctrl2 = wr_i && (addr_i == ADDR_T2_CTRL);
    assign wr_stat  = wr_i && (addr_i == ADDR_IRQ_STAT);

    // control registers; reserved bits held at zero
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            t1_ctrl_q <= CTRL_RST;
            t2_ctrl_q <= CTRL_RST;
        end else begin
            if (wr_ctrl1) begin
                t1_ctrl_q <= wdata_i & CTRL_WMASK;
            end
            if (wr_ctrl2) begin
                t2_ctrl_q <= wdata_i & CTRL_WMASK;
            end
        end
    end

    // reload bytes; the core samples them on start and on auto reload
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            t1_rld_hi_q <= RELOAD_RST;
            t1_rld_lo_q <= RELOAD_RST;
        end else if (wr_i) begin
            if (addr_i == ADDR_T1_RLD_HI) begin
                t1_rld_hi_q <= wdata_i; // R11
            end
            if (addr_i == ADDR_T1_RLD_LO) begin
                t1_rld_lo_q <= wdata_i; // R11
            end
        end
    end

    // ************************************************
    // interrupt flags and mask
    // ************************************************
    assign uf_set = {t2_uf, t1_uf};

    // sticky flags, write one to clear, set wins
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            stat_q <= IRQ_RST;
        end else begin
            stat_q <= (stat_q & ~(wr_stat ? wdata_i[1:0] : 2'h0)) | uf_set; // R8 R16
        end
    end

    // mask register
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            mask_q <= IRQ_RST;
        end else if (wr_i && addr_i == ADDR_IRQ_MASK) begin
            mask_q <= wdata_i[1:0];
        end
    end

    // interrupt level from flop
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(((stat_q & ~(wr_stat ? wdata_i[1:0] : 2'h0)) | uf_set) & mask_q);
        end
    end

    // ************************************************
    // read path
    // ************************************************
    // read mux, unmapped reads zero
    always_comb begin
        rdata_d = 8'h00;
        case (addr_i)
            ADDR_T0_CNT_LO: rdata_d = timer0_count_low_i;
            ADDR_T1_CTRL:   rdata_d = t1_ctrl_q;
            ADDR_T1_RLD_HI: rdata_d = t1_rld_hi_q;
            ADDR_T1_RLD_LO: rdata_d = t1_rld_lo_q;
            ADDR_T1_CNT_HI: rdata_d = t1_count[15:8]; // R1
            ADDR_T1_CNT_LO: rdata_d = t1_count[7:0];  // R1
            ADDR_T2_CTRL:   rdata_d = t2_ctrl_q;
            ADDR_IRQ_STAT:  rdata_d = {6'h00, stat_q};
            ADDR_IRQ_MASK:  rdata_d = {6'h00, mask_q};
            default:        rdata_d = 8'h00;
        endcase
    end

    // read data stands one cycle after the strobe only
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= rdata_d;
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // ************************************************
    // status outputs, registered copies
    // ************************************************
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            timer1_running_o   <= 1'b0;
            timer2_running_o   <= 1'b0;
            timer1_underflow_o <= 1'b0;
            timer2_underflow_o <= 1'b0;
        end else begin
            timer1_running_o   <= t1_run;
            timer2_running_o   <= t2_run;
            timer1_underflow_o <= t1_uf;
            timer2_underflow_o <= t2_uf;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    chk_t1_count_read : assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R1
        rd_i && addr_i == ADDR_T1_CNT_LO |=> rdata_o == $past(t1_count[7:0]))
        else $error("count low byte read wrong");
    chk_t1_flag_set : assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R8
        t1_uf |=> stat_q[IRQ_T1_BIT]) else $error("timer1 flag not set");
    chk_t2_flag_set : assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R16
        t2_uf |=> stat_q[IRQ_T2_BIT]) else $error("timer2 flag not set");
    chk_t1_chain : assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R9
        t1_ctrl_q[CLK_LSB+:2] == CLK_OTHER |-> t1_tick == t2_uf)
        else $error("timer1 chain source wrong");
    chk_t2_chain : assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R17
        t2_ctrl_q[CLK_LSB+:2] == CLK_OTHER |-> t2_tick == t1_uf)
        else $error("timer2 chain source wrong");
    chk_run_enable : assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R18
        !timer1_run_write_enable_i && !tx_end_i && !lfo_rise && !rx_first4_i && !t1_tick
        |=> t1_run == $past(t1_run)) else $error("running changed without enable");
    chk_reload_quiet : assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R11
        wr_i && addr_i == ADDR_T1_RLD_LO && t1_run && !t1_tick && !timer1_run_write_enable_i
        && !lfo_rise && !rx_first4_i |=> $stable(t1_count)) else $error("reload write moved count");
    chk_tx_start : assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R5
        !t1_run && tx_end_i && t1_ctrl_q[START_LSB+:2] == START_TX_END
        && !timer1_run_write_enable_i |=> t1_run) else $error("no start at tx end");
endmodule
`default_nettype wire

// >>> design/rft_tmr_core.sv
// one 16-bit down counter with start, stop, reload and underflow
// assumes tick and event inputs are one-cycle pulses on mclk_i
`timescale 1ns/1ps
`default_nettype none
module rft_tmr_core (
    input  wire logic               mclk_i,        // block clock
    input  wire logic               rst_n_i,       // synchronous reset, active low
    input  wire logic               stop_rx_i,     // stop on first received bits
    input  wire rft_pkg::rft_start_t start_mode_i, // start mode
    input  wire logic               auto_reload_i, // restart after zero
    input  wire logic [15:0]        reload_i,      // reload value
    input  wire logic               tick_i,        // selected count clock pulse
    input  wire logic               tx_end_i,      // end of transmission pulse
    input  wire logic               rx_first4_i,   // first 4 bits received pulse
    input  wire logic               lfo_rise_i,    // oscillator rising edge pulse
    input  wire logic               run_we_i,      // running bit may change
    input  wire logic               run_val_i,     // new running bit
    output logic [15:0]             count_o,       // current count
    output logic                    running_o,     // counting
    output logic                    uflow_o        // underflow pulse, registered
);
    import rft_pkg::*;

    rft_state_t  state_q;   // run state
    logic [15:0] count_q;   // counter
    logic        lfo_mode;  // trimming selected
    logic        is_run;    // in run state
    logic        start_ev;  // any start
    logic        stop_ev;   // any stop
    logic        at_zero;   // counter is zero
    logic        step;      // a count step this cycle
    logic        uf_now;    // underflow this cycle

    assign lfo_mode = start_mode_i[1];
    assign is_run   = (state_q == ST_RUN);
    assign at_zero  = (count_q == 16'h0000);
    // software or automatic start
    assign start_ev = (run_we_i & run_val_i) // R18
                    | (~is_run & start_mode_i == START_TX_END & tx_end_i) // R5
                    | (~is_run & lfo_mode & lfo_rise_i); // R6
    // software, trimming edge or receive stop; receive stop off in trimming
    assign stop_ev  = (run_we_i & ~run_val_i)
                    | (is_run & lfo_mode & lfo_rise_i) // R6
                    | (is_run & stop_rx_i & ~lfo_mode & rx_first4_i); // R3 R4 R12 R13
    assign step     = tick_i & is_run & ~start_ev & ~stop_ev; // R19
    assign uf_now   = step & at_zero & (start_mode_i != START_LFO_NOUF); // R6 R19

    // ************************************************
    // run state
    // ************************************************
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
        end else begin
            case (1'b1)
                stop_ev:                   state_q <= ST_IDLE;
                start_ev:                  state_q <= ST_RUN;
                uf_now & ~auto_reload_i:   state_q <= ST_IDLE; // R7
                default:                   state_q <= state_q;
            endcase
        end
    end

    // ************************************************
    // counter and underflow pulse
    // ************************************************
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            count_q <= 16'h0000;
            uflow_o <= 1'b0;
        end else begin
            uflow_o <= uf_now;
            if (start_ev && !stop_ev) begin
                count_q <= reload_i; // R10 R11
            end else if (uf_now && auto_reload_i) begin
                count_q <= reload_i; // R7 R15
            end else if (step && !at_zero) begin
                count_q <= count_q - 16'h0001; // R19
            end
        end
    end

    assign count_o   = count_q;
    assign running_o = state_q;

    chk_start_loads : assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R10
        start_ev && !stop_ev |=> count_q == $past(reload_i)) else $error("start missed reload");
    chk_rx_stop : assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R3
        is_run && stop_rx_i && !lfo_mode && rx_first4_i && !start_ev |=> !is_run)
        else $error("receive stop ignored");
    chk_lfo_no_rx : assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R4
        is_run && lfo_mode && !lfo_rise_i && !run_we_i && !tick_i |=> is_run)
        else $error("timer stopped in trimming mode");
    chk_auto_reload : assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R7
        uf_now && !auto_reload_i |=> !is_run ##1 $stable(count_q) || !is_run)
        else $error("one-shot timer kept running");
    chk_decrement : assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R19
        step && !at_zero |=> count_q == $past(count_q) - 16'h0001)
        else $error("count step wrong");
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// bench: register port and timer runs against an integer count model
// assumes rft_timer_ctrl alone on one 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rft_pkg::*;
    // ********
    // signals
    // ********
    logic       mclk_i = '0, rst_n_i = '0, wr = '0, rd = '0, rf = '0, dv = '0;
    logic       low_freq_oscillator = '0, txe = '0, rx4 = '0, we1 = '0, rv1 = '0, we2 = '0, rv2 = '0, t0u = '0;
    logic [7:0] addr = '0, wd = '0, t0c = '0, rdv;
    logic       r1o, r2o, u1o, u2o, irq;
    int         failures = 0, checks = 0, seed = 69152, m, n1 = 0, n2 = 0;
    always #12.5 mclk_i = ~mclk_i;
    // count underflow pulses seen on the outputs
    always @(posedge mclk_i) begin
        if (u1o === 1'b1) n1++;
        if (u2o === 1'b1) n2++;
    end
    rft_timer_ctrl DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wd),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdv), .rf_clk_i(rf), .div_clk_i(dv),
        .low_freq_oscillator_i(low_freq_oscillator), .tx_end_i(txe), .rx_first4_i(rx4),
        .timer0_underflow_i(t0u), .timer0_count_low_i(t0c),
        .timer1_run_write_enable_i(we1), .timer1_running_i(rv1),
        .timer2_run_write_enable_i(we2), .timer2_running_i(rv2),
        .timer1_running_o(r1o), .timer2_running_o(r2o), .timer1_underflow_o(u1o),
        .timer2_underflow_o(u2o), .irq_o(irq));
    // ********
    // tasks
    // ********
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i) {wr, addr, wd} <= {1'b1, a, d};
        @(posedge mclk_i) wr <= '0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_i) {rd, addr} <= {1'b1, a};
        @(posedge mclk_i) rd <= '0;
        #1 chk(rdv, e);
    endtask
    task automatic cnt(input int e);
        rreg(ADDR_T1_CNT_HI, e[15:8]);
        rreg(ADDR_T1_CNT_LO, e[7:0]);
    endtask
    // one slow edge on carrier (s=1) or divided carrier
    task automatic tick(input bit s);
        @(posedge mclk_i) {rf, dv} <= s ? 2'b10 : 2'b01;
        cyc(5);
        {rf, dv} <= '0;
        cyc(5);
    endtask
    task automatic run1(input logic v);
        @(posedge mclk_i) {we1, rv1} <= {1'b1, v};
        @(posedge mclk_i) we1 <= '0;
        cyc(3);
    endtask
    task automatic tally_and_finish;
        $display("failures %0d checks %0d", failures, checks);
        if (failures == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wirq;
        for (int i = 0; i < 40 && irq !== 1'b1; i++) cyc(1);
        if (irq !== 1'b1) begin
            failures++;
            tally_and_finish;
        end
    endtask
    // ********
    // sequence
    // ********
    initial begin
        cyc(2);
        rst_n_i <= 1'b1;
        rreg(ADDR_T1_CTRL, CTRL_RST);
        rreg(8'h30, 8'h00);
        wreg(ADDR_T1_CTRL, 8'hff);
        rreg(ADDR_T1_CTRL, CTRL_WMASK);
        m = $random(seed);
        @(posedge mclk_i) t0c <= m[7:0];
        rreg(ADDR_T0_CNT_LO, m[7:0]);
        m = ($random(seed) & 32'h0000ff00) | 32'h00000010;
        wreg(ADDR_T1_CTRL, 8'h01);
        wreg(ADDR_T1_RLD_HI, m[15:8]);
        wreg(ADDR_T1_RLD_LO, m[7:0]);
        run1(1'b1);
        cnt(m);
        tick(0);
        tick(0);
        wreg(ADDR_T1_RLD_LO, 8'h00);
        tick(0);
        m -= 3;
        cnt(m);
        run1(1'b0);
        @(posedge mclk_i) rv1 <= 1'b1;
        cyc(3);
        chk({7'h0, r1o}, 8'h00);
        wreg(ADDR_IRQ_MASK, 8'h03);
        wreg(ADDR_T1_RLD_HI, 8'h00);
        wreg(ADDR_T1_RLD_LO, 8'h01);
        run1(1'b1);
        tick(0);
        tick(0);
        wirq();
        rreg(ADDR_IRQ_STAT, 8'h01);
        chk({7'h0, r1o}, 8'h00);
        wreg(ADDR_IRQ_STAT, 8'h01);
        rreg(ADDR_IRQ_STAT, 8'h00);
        wreg(ADDR_T1_CTRL, 8'h09);
        run1(1'b1);
        tick(0);
        tick(0);
        chk({7'h0, r1o}, 8'h01);
        cnt(1);
        wreg(ADDR_T1_CTRL, 8'h81);
        @(posedge mclk_i) rx4 <= 1'b1;
        @(posedge mclk_i) rx4 <= '0;
        cyc(3);
        chk({7'h0, r1o}, 8'h00);
        wreg(ADDR_T1_CTRL, 8'ha1);
        @(posedge mclk_i) low_freq_oscillator <= 1'b1;
        cyc(6);
        rx4 <= 1'b1;
        @(posedge mclk_i) rx4 <= '0;
        cyc(3);
        chk({7'h0, r1o}, 8'h01);
        run1(1'b0);
        wreg(ADDR_T1_CTRL, 8'h11);
        @(posedge mclk_i) txe <= 1'b1;
        @(posedge mclk_i) txe <= '0;
        cyc(3);
        chk({7'h0, r1o}, 8'h01);
        run1(1'b0);
        wreg(ADDR_IRQ_STAT, 8'h03);
        wreg(ADDR_T2_CTRL, 8'h00);
        @(posedge mclk_i) {we2, rv2} <= 2'b11;
        @(posedge mclk_i) we2 <= '0;
        tick(1);
        wirq();
        rreg(ADDR_IRQ_STAT, 8'h02);
        chk({7'h0, r2o}, 8'h00);
        wreg(ADDR_T1_CTRL, 8'h02);
        run1(1'b1);
        repeat (2) begin
            @(posedge mclk_i) t0u <= 1'b1;
            @(posedge mclk_i) t0u <= '0;
        end
        cyc(3);
        chk({7'h0, r1o}, 8'h00);
        chk(8'(n1), 8'h03);
        chk(8'(n2), 8'h01);
        tally_and_finish;
    end
endmodule
`default_nettype wire
